// File: shared/sgd_pkg.sv
// Constants and types shared by the SIMD general data datapath
package sgd_pkg;
    localparam logic [3:0]  OFS_STATUS     = 4'h0;
    localparam logic [3:0]  OFS_CTRL       = 4'h4;
    localparam int unsigned SAT_BIT        = 27;
    localparam int unsigned HALF_EN_BIT    = 0;
    localparam logic        HALF_EN_RST    = 1'b1;
    localparam logic [5:0]  FBITS_MAX      = 6'h20;
    localparam logic [7:0]  EXT_MAX_D      = 8'h07;
    localparam logic [7:0]  EXT_MAX_Q      = 8'h0F;
    localparam int          F32_BIAS       = 127;
    localparam int          F32_MAN_W      = 23;
    localparam int          F2I_SH_MAX     = 40;
    localparam logic [7:0]  F32_EXP_MAX    = 8'hFF;
    localparam logic [4:0]  F16_EXP_MAX    = 5'h1F;
    localparam int          F16_REBIAS     = 112;
    localparam logic [7:0]  F16_REBIAS_8   = 8'h70;
    localparam logic [7:0]  FIMM_EXP_BASE  = 8'h83;
    localparam logic [2:0]  SHAPE_I32_LAST = 3'h5;
    localparam logic [3:0]  REV_K_HALF     = 4'h1;
    localparam logic [3:0]  REV_K_WORD     = 4'h3;
    localparam logic [3:0]  REV_K_DWORD    = 4'h7;

    typedef enum logic [1:0] {
        ES8  = 2'b00,
        ES16 = 2'b01,
        ES32 = 2'b10,
        ES64 = 2'b11
    } sgd_esize_t;

    typedef enum logic [4:0] {
        OP_CONV_F2S       = 5'h00,
        OP_CONV_F2U       = 5'h01,
        OP_CONV_S2F       = 5'h02,
        OP_CONV_U2F       = 5'h03,
        OP_CONV_H2F       = 5'h04,
        OP_CONV_F2H       = 5'h05,
        OP_LANE_DUP       = 5'h06,
        OP_CORE_DUP       = 5'h07,
        OP_BYTE_EXTRACT   = 5'h08,
        OP_IMM_FILL       = 5'h09,
        OP_INV_IMM_FILL   = 5'h0A,
        OP_WIDEN          = 5'h0B,
        OP_TRUNC_NARROW   = 5'h0C,
        OP_SAT_NARROW     = 5'h0D,
        OP_SAT_NARROW_SU  = 5'h0E,
        OP_REV_HALF       = 5'h0F,
        OP_REV_WORD       = 5'h10,
        OP_REV_DWORD      = 5'h11
    } sgd_op_t;
endpackage : sgd_pkg

// File: hw/sgd_datapath.sv
// SIMD general data datapath: conversions, fills, moves, reversals
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Integer or fixed to float rounds nearest
// - Float to integer or fixed truncates
// - Four 32-bit conversion pairings, per lane
// - Fraction count 0 to 32 selects fixed
// - Optional half to single and back
// - Duplicate lane or core scalar everywhere
// - Extract concatenates bytes, count 0-7/0-15
// - Immediate fill replicates encoded value
// - 32-bit immediate: one byte, any position, or ones-filled below it
// - 64-bit immediate: byte masks only
// - Float immediate is n times two to r
// - Inverted fill, 16 and 32 bit only
// - Widen sign or zero extends to quadword
// - Plain narrow keeps low half
// - Saturating narrow clamps to half width
// - Signed source, unsigned result narrow clamps
// - Swap bytes within each halfword
// - Reverse elements within each word
// - Reverse elements within each doubleword
// - Any lane saturation sets the flag
// - Flag is sticky at status bit 27
// - Clamp limits follow destination type range
module sgd_datapath (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               op_valid,
    input  wire sgd_pkg::sgd_op_t   op_code,
    input  wire logic               op_quad,
    input  wire logic [1:0]         op_esize,
    input  wire logic               op_unsigned,
    input  wire logic [5:0]         op_fbits,
    input  wire logic [3:0]         op_lane,
    input  wire logic [7:0]         op_imm,
    input  wire logic [2:0]         op_imm_shape,
    input  wire logic               op_imm_float,
    input  wire logic [127:0]       opa,
    input  wire logic [127:0]       opb,
    input  wire logic [31:0]        core_scalar,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    output logic                    res_valid,
    output logic      [127:0]       res_data,
    output logic                    res_illegal,
    output logic                    sat_flag
);
    logic half_en;

    function automatic logic [31:0] f2i(input logic [31:0] x,
                                        input logic [5:0]  fb,
                                        input logic        uns);
        logic [63:0] mag;
        logic [63:0] man;
        logic [31:0] r;
        int          sh;
        man = {40'h0, 1'b1, x[22:0]};
        sh  = int'(x[30:23]) - sgd_pkg::F32_BIAS - sgd_pkg::F32_MAN_W
              + int'(fb);
        mag = 64'h0;
        if (x[30:23] == 8'h00)
            mag = 64'h0;
        else if (sh >= sgd_pkg::F2I_SH_MAX)
            mag = {64{1'b1}};
        else if (sh >= 0)
            mag = man << sh;
        else if (sh > -(sgd_pkg::F32_MAN_W + 1))
            mag = man >> (-sh);
        // Bits below the binary point are dropped: round toward zero
        if (x[30:23] == sgd_pkg::F32_EXP_MAX && x[22:0] != 23'h0)
            r = 32'h0;
        else if (uns)
            r = x[31] ? 32'h0 :
                (mag[63:32] != 32'h0) ? 32'hFFFF_FFFF : mag[31:0];
        else if (!x[31])
            r = (mag > 64'h0000_0000_7FFF_FFFF) ? 32'h7FFF_FFFF
                                                : mag[31:0];
        else
            r = (mag > 64'h0000_0000_8000_0000) ? 32'h8000_0000
                                                : ~mag[31:0] + 32'h1;
        return r;
    endfunction : f2i

    function automatic logic [31:0] i2f(input logic [31:0] v,
                                        input logic [5:0]  fb,
                                        input logic        uns);
        logic        neg;
        logic        up;
        logic [31:0] mag;
        logic [31:0] nrm;
        logic [23:0] fr;
        logic [7:0]  ex;
        int          p;
        neg = !uns && v[31];
        mag = neg ? ~v + 32'h1 : v;
        p   = 0;
        for (int k = 0; k < 32; k++)
            if (mag[k])
                p = k;
        nrm = mag << (31 - p);
        // Round to nearest, ties to even on the kept lsb
        up  = nrm[7] && ((nrm[6:0] != 7'h0) || nrm[8]);
        fr  = {1'b0, nrm[30:8]} + {23'h0, up};
        ex  = 8'(sgd_pkg::F32_BIAS + p - int'(fb) + int'(fr[23]));
        return (mag == 32'h0) ? 32'h0 : {neg, ex, fr[22:0]};
    endfunction : i2f

    // Subnormal halves flush to signed zero
    function automatic logic [31:0] h2f(input logic [15:0] h);
        if (h[14:10] == 5'h00)
            return {h[15], 31'h0};
        else if (h[14:10] == sgd_pkg::F16_EXP_MAX)
            return {h[15], sgd_pkg::F32_EXP_MAX, h[9:0], 13'h0};
        return {h[15], {3'h0, h[14:10]} + sgd_pkg::F16_REBIAS_8,
                h[9:0], 13'h0};
    endfunction : h2f

    function automatic logic [15:0] f2h(input logic [31:0] x);
        logic        up;
        logic [10:0] fr;
        int          e;
        e  = int'(x[30:23]) - sgd_pkg::F16_REBIAS;
        up = x[12] && ((x[11:0] != 12'h0) || x[13]);
        fr = {1'b0, x[22:13]} + {10'h0, up};
        if (x[30:23] == sgd_pkg::F32_EXP_MAX)
            return {x[31], sgd_pkg::F16_EXP_MAX, x[22:0] != 23'h0,
                    x[21:13]};
        else if (e <= 0)
            return {x[31], 15'h0};
        else if (e + int'(fr[10]) >= int'(sgd_pkg::F16_EXP_MAX))
            return {x[31], sgd_pkg::F16_EXP_MAX, 10'h0};
        return {x[31], 5'(e + int'(fr[10])), fr[9:0]};
    endfunction : f2h

    // Conversion lanes
    wire logic [127:0] cvt_f2i;
    wire logic [127:0] cvt_i2f;
    wire logic [127:0] cvt_h2f;
    wire logic [63:0]  cvt_f2h;
    wire logic         cvt_uns;
    wire logic         fb_ok;
    assign cvt_uns = (op_code == sgd_pkg::OP_CONV_F2U) ||
                     (op_code == sgd_pkg::OP_CONV_U2F);
    assign fb_ok   = op_fbits <= sgd_pkg::FBITS_MAX;

    for (genvar i = 0; i < 4; i++) begin : g_cvt
        assign cvt_f2i[32*i +: 32] = f2i(opa[32*i +: 32], op_fbits,
                                         cvt_uns);
        assign cvt_i2f[32*i +: 32] = i2f(opa[32*i +: 32], op_fbits,
                                         cvt_uns);
        assign cvt_h2f[32*i +: 32] = h2f(opa[16*i +: 16]);
        assign cvt_f2h[16*i +: 16] = f2h(opa[32*i +: 32]);
    end

    // Duplicate: lanes come from the low doubleword only
    wire logic [6:0]   lane_off;
    wire logic [31:0]  lane_word;
    wire logic [31:0]  dup_src;
    wire logic [127:0] dup_fill;
    wire logic         lane_ok;
    assign lane_off  = {3'h0, op_lane} << (3'h3 + {1'b0, op_esize});
    assign lane_word = 32'(opa[63:0] >> lane_off);
    assign lane_ok   = ({3'h0, op_lane} << op_esize) < 7'h08;
    assign dup_src   = (op_code == sgd_pkg::OP_CORE_DUP) ? core_scalar
                                                         : lane_word;
    assign dup_fill  = (op_esize == sgd_pkg::ES8)  ? {16{dup_src[7:0]}} :
                       (op_esize == sgd_pkg::ES16) ? {8{dup_src[15:0]}} :
                       {4{dup_src}};

    // Extract: second operand bytes sit above the first
    wire logic [255:0] ext_cat;
    wire logic [127:0] ext_res;
    wire logic         ext_ok;
    assign ext_cat = op_quad ? {opb, opa}
                             : {128'h0, opb[63:0], opa[63:0]};
    assign ext_res = 128'(ext_cat >> {op_imm[3:0], 3'h0});
    // Wider-element counts arrive already scaled to bytes
    assign ext_ok  = op_imm <= (op_quad ? sgd_pkg::EXT_MAX_Q
                                        : sgd_pkg::EXT_MAX_D);

    // Immediate expansion
    wire logic [31:0] imm_sh;
    wire logic [31:0] imm32;
    wire logic [15:0] imm16;
    wire logic [63:0] imm64;
    wire logic [31:0] fimm;
    wire logic [63:0] fill64;
    wire logic        imm_ok;
    wire logic        inv_ok;
    assign imm_sh = {24'h0, op_imm} << {op_imm_shape[1:0], 3'h0};
    assign imm32  = !op_imm_shape[2]   ? imm_sh :
                    !op_imm_shape[0]   ? {16'h0, op_imm, 8'hFF} :
                    {8'h0, op_imm, 16'hFFFF};
    assign imm16  = op_imm_shape[0] ? {op_imm, 8'h00} : {8'h00, op_imm};
    for (genvar k = 0; k < 8; k++) begin : g_mask
        assign imm64[8*k +: 8] = {8{op_imm[k]}};
    end
    // Sign, r in bits 6:4, n minus 16 in bits 3:0
    assign fimm   = {op_imm[7], sgd_pkg::FIMM_EXP_BASE +
                     {5'h0, op_imm[6:4]}, op_imm[3:0], 19'h0};
    assign fill64 = op_imm_float               ? {2{fimm}} :
                    (op_esize == sgd_pkg::ES8)  ? {8{op_imm}} :
                    (op_esize == sgd_pkg::ES16) ? {4{imm16}} :
                    (op_esize == sgd_pkg::ES32) ? {2{imm32}} : imm64;
    assign imm_ok = op_imm_float ? (op_esize == sgd_pkg::ES32) :
                    (op_esize == sgd_pkg::ES16) ? (op_imm_shape < 3'h2) :
                    (op_esize == sgd_pkg::ES32) ?
                        (op_imm_shape <= sgd_pkg::SHAPE_I32_LAST) :
                    (op_imm_shape == 3'h0);
    assign inv_ok = imm_ok && !op_imm_float &&
                    ((op_esize == sgd_pkg::ES16) ||
                     (op_esize == sgd_pkg::ES32));

    // Widen and narrow, one generate block per element width
    wire logic         su_mode;
    wire logic         sat_uns;
    wire logic [2:0][127:0] widen_res;
    wire logic [2:0][63:0]  trunc_res;
    wire logic [2:0][63:0]  nar_res;
    wire logic [2:0]        any_sat;
    assign su_mode = op_code == sgd_pkg::OP_SAT_NARROW_SU;
    assign sat_uns = su_mode || op_unsigned;

    for (genvar g = 0; g < 3; g++) begin : g_sz
        localparam int W = 8 << g;
        localparam int N = 64 / W;
        wire logic [N-1:0] sat;
        for (genvar i = 0; i < N; i++) begin : g_el
            wire logic [2*W-1:0] src;
            wire logic [W-1:0]   el;
            wire logic [W-1:0]   lim;
            wire logic           fit_s;
            wire logic           fit_u;
            wire logic           neg;
            assign src   = opa[2*W*i +: 2*W];
            assign el    = opa[W*i +: W];
            assign neg   = src[2*W-1];
            assign fit_s = (&src[2*W-1:W-1]) || !(|src[2*W-1:W-1]);
            assign fit_u = !(|src[2*W-1:W]);
            assign sat[i] = su_mode ? (neg || !fit_u) :
                            op_unsigned ? !fit_u : !fit_s;
            assign lim = sat_uns ? ((su_mode && neg) ? {W{1'b0}}
                                                     : {W{1'b1}}) :
                         {neg, {(W-1){!neg}}};
            assign widen_res[g][2*W*i +: 2*W] =
                {{W{!op_unsigned && el[W-1]}}, el};
            assign trunc_res[g][W*i +: W] = src[W-1:0];
            assign nar_res[g][W*i +: W] = sat[i] ? lim : src[W-1:0];
        end
        assign any_sat[g] = |sat;
    end

    wire logic [1:0] widx;
    wire logic [1:0] nidx;
    assign widx = (op_esize == sgd_pkg::ES64) ? 2'h0 : op_esize;
    assign nidx = (op_esize == sgd_pkg::ES8)  ? 2'h0 : op_esize - 2'h1;

    // Reverse: byte j takes byte j xor mask inside its container
    wire logic [3:0]   rev_k;
    wire logic [3:0]   rev_e;
    wire logic [3:0]   rev_mask;
    wire logic [127:0] rev_res;
    wire logic         rev_ok;
    assign rev_k    = (op_code == sgd_pkg::OP_REV_HALF) ?
                          sgd_pkg::REV_K_HALF :
                      (op_code == sgd_pkg::OP_REV_WORD) ?
                          sgd_pkg::REV_K_WORD : sgd_pkg::REV_K_DWORD;
    assign rev_e    = (4'h1 << op_esize) - 4'h1;
    assign rev_mask = rev_k & ~rev_e;
    assign rev_ok   = rev_e < rev_k;
    for (genvar j = 0; j < 16; j++) begin : g_rev
        assign rev_res[8*j +: 8] = opa[8*(j ^ rev_mask) +: 8];
    end

    // Result selection
    logic [127:0] next_res;
    logic         next_legal;
    logic         next_dq;
    logic         sat_ev;
    always_comb begin
        next_res   = 128'h0;
        next_legal = 1'b1;
        next_dq    = op_quad;
        sat_ev     = 1'b0;
        case (op_code)
            sgd_pkg::OP_CONV_F2S, sgd_pkg::OP_CONV_F2U: begin
                next_res   = cvt_f2i;
                next_legal = fb_ok;
            end
            sgd_pkg::OP_CONV_S2F, sgd_pkg::OP_CONV_U2F: begin
                next_res   = cvt_i2f;
                next_legal = fb_ok;
            end
            sgd_pkg::OP_CONV_H2F: begin
                next_res   = cvt_h2f;
                next_dq    = 1'b1;
                next_legal = half_en;
            end
            sgd_pkg::OP_CONV_F2H: begin
                next_res   = {64'h0, cvt_f2h};
                next_dq    = 1'b0;
                next_legal = half_en;
            end
            sgd_pkg::OP_LANE_DUP: begin
                next_res   = dup_fill;
                next_legal = lane_ok && (op_esize != sgd_pkg::ES64);
            end
            sgd_pkg::OP_CORE_DUP: begin
                next_res   = dup_fill;
                next_legal = op_esize != sgd_pkg::ES64;
            end
            sgd_pkg::OP_BYTE_EXTRACT: begin
                next_res   = ext_res;
                next_legal = ext_ok;
            end
            sgd_pkg::OP_IMM_FILL: begin
                next_res   = {2{fill64}};
                next_legal = imm_ok;
            end
            sgd_pkg::OP_INV_IMM_FILL: begin
                next_res   = ~{2{fill64}};
                next_legal = inv_ok;
            end
            sgd_pkg::OP_WIDEN: begin
                next_res   = widen_res[widx];
                next_dq    = 1'b1;
                next_legal = op_esize != sgd_pkg::ES64;
            end
            sgd_pkg::OP_TRUNC_NARROW: begin
                next_res   = {64'h0, trunc_res[nidx]};
                next_dq    = 1'b0;
                next_legal = op_esize != sgd_pkg::ES8;
            end
            sgd_pkg::OP_SAT_NARROW, sgd_pkg::OP_SAT_NARROW_SU: begin
                next_res   = {64'h0, nar_res[nidx]};
                next_dq    = 1'b0;
                next_legal = op_esize != sgd_pkg::ES8;
                sat_ev     = op_valid && any_sat[nidx];
            end
            sgd_pkg::OP_REV_HALF, sgd_pkg::OP_REV_WORD,
            sgd_pkg::OP_REV_DWORD: begin
                next_res   = rev_res;
                next_legal = rev_ok;
            end
            default: begin
                next_legal = 1'b0;
            end
        endcase
        // Illegal encodings give zero and never touch the flag
        if (!next_legal) begin
            next_res = 128'h0;
            sat_ev   = 1'b0;
        end
        if (!next_dq)
            next_res[127:64] = 64'h0;
    end

    // Register port
    wire logic wr_status;
    wire logic wr_ctrl;
    wire logic next_sat;
    wire logic [31:0] rd_mux;
    assign wr_status = reg_wr && (reg_addr == sgd_pkg::OFS_STATUS);
    assign wr_ctrl   = reg_wr && (reg_addr == sgd_pkg::OFS_CTRL);
    // Hardware set wins over a software clear in the same cycle
    assign next_sat  = sat_ev ||
                       (wr_status ? reg_wdata[sgd_pkg::SAT_BIT]
                                  : sat_flag);
    assign rd_mux = (reg_addr == sgd_pkg::OFS_STATUS) ?
                        32'(sat_flag) << sgd_pkg::SAT_BIT :
                    (reg_addr == sgd_pkg::OFS_CTRL) ?
                        32'(half_en) << sgd_pkg::HALF_EN_BIT :
                    32'h0000_0000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sat_flag  <= 1'b0;
            half_en   <= sgd_pkg::HALF_EN_RST;
            reg_rdata <= 32'h0000_0000;
        end else begin
            sat_flag  <= next_sat;
            if (wr_ctrl)
                half_en <= reg_wdata[sgd_pkg::HALF_EN_BIT];
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            res_valid   <= 1'b0;
            res_illegal <= 1'b0;
            res_data    <= 128'h0;
        end else begin
            res_valid   <= op_valid;
            res_illegal <= op_valid && !next_legal;
            if (op_valid)
                res_data <= next_res;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_issue(sgd_pkg::sgd_op_t o);
        op_valid && op_code == o;
    endsequence
    sequence s_keep_flag;
        sat_flag && !(wr_status && !reg_wdata[sgd_pkg::SAT_BIT]);
    endsequence

    chk_sat_sticky: assert property (s_keep_flag |=> sat_flag)
        else $error("saturation flag dropped without a clear");
    chk_sat_raise: assert property (
        s_issue(sgd_pkg::OP_SAT_NARROW) ##0 (op_esize == sgd_pkg::ES16)
        ##0 (opa[15:7] == 9'h100) |=> sat_flag)
        else $error("saturating lane did not raise the flag");
    chk_sat_clamp: assert property (
        s_issue(sgd_pkg::OP_SAT_NARROW) ##0 (op_esize == sgd_pkg::ES16)
        ##0 (!op_unsigned && opa[15] && !(&opa[14:7]))
        |=> res_data[7:0] == 8'h80)
        else $error("signed narrow did not clamp to minimum");
    chk_su_neg: assert property (
        s_issue(sgd_pkg::OP_SAT_NARROW_SU) ##0
        (op_esize == sgd_pkg::ES16 && opa[15])
        |=> res_data[7:0] == 8'h00 && sat_flag)
        else $error("negative source not clamped to zero");
    chk_trunc_low: assert property (
        s_issue(sgd_pkg::OP_TRUNC_NARROW) ##0 (op_esize == sgd_pkg::ES32)
        |=> res_data[15:0] == $past(opa[15:0]) &&
            res_data[127:64] == 64'h0)
        else $error("plain narrow lost the low half");
    chk_rev_half: assert property (
        s_issue(sgd_pkg::OP_REV_HALF) ##0 (op_esize == sgd_pkg::ES8)
        |=> res_data[15:0] == {$past(opa[7:0]), $past(opa[15:8])})
        else $error("halfword byte swap wrong");
    chk_rev_dword: assert property (
        s_issue(sgd_pkg::OP_REV_DWORD) ##0 (op_esize == sgd_pkg::ES32)
        |=> res_data[63:0] == {$past(opa[31:0]), $past(opa[63:32])})
        else $error("doubleword word reversal wrong");
    chk_dup_core: assert property (
        s_issue(sgd_pkg::OP_CORE_DUP) ##0
        (op_esize == sgd_pkg::ES16 && !op_quad)
        |=> res_data[63:48] == $past(core_scalar[15:0]) &&
            res_data[127:64] == 64'h0)
        else $error("core scalar not in every lane");
    chk_ext_count: assert property (
        s_issue(sgd_pkg::OP_BYTE_EXTRACT) ##0
        (op_quad && op_imm == sgd_pkg::EXT_MAX_Q)
        |=> res_data[7:0] == $past(opa[127:120]) &&
            res_data[127:120] == $past(opb[119:112]))
        else $error("extract byte placement wrong");
    chk_widen_sign: assert property (
        s_issue(sgd_pkg::OP_WIDEN) ##0
        (op_esize == sgd_pkg::ES8 && !op_unsigned && opa[7])
        |=> res_data[15:8] == 8'hFF)
        else $error("widen did not sign extend");
    chk_inv_fill: assert property (
        s_issue(sgd_pkg::OP_INV_IMM_FILL) ##0
        (op_esize == sgd_pkg::ES16 && !op_imm_float &&
         op_imm_shape == 3'h1)
        |=> res_data[15:0] == ~{$past(op_imm), 8'h00})
        else $error("inverted fill not complemented");
endmodule : sgd_datapath
`default_nettype wire

// File: sim/sgd_issuer.sv
// Issue-side model: presents one operation per call, like the issue stage
`timescale 1ns/1ps
`default_nettype none
module sgd_issuer (
    input  wire logic             clk,
    output var  logic             op_valid = 1'b0,
    output var  sgd_pkg::sgd_op_t op_code = sgd_pkg::OP_REV_HALF,
    output var  logic             op_quad = 1'b0,
    output var  logic [1:0]       op_esize = 2'h0,
    output var  logic             op_unsigned = 1'b0,
    output var  logic [7:0]       op_imm = 8'h00,
    output var  logic [2:0]       op_imm_shape = 3'h0,
    output var  logic [127:0]     opa = 128'h0,
    output var  logic [127:0]     opb = 128'h0
);
    task automatic issue(input sgd_pkg::sgd_op_t c, input logic q,
                         input logic [1:0] e, input logic u,
                         input logic [7:0] i, input logic [2:0] s,
                         input logic [127:0] a, input logic [127:0] b);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= c;
        op_quad <= q;
        op_esize <= e;
        op_unsigned <= u;
        op_imm <= i;
        op_imm_shape <= s;
        opa <= a;
        opb <= b;
        @(posedge clk);
        op_valid <= 1'b0;
        // Operands no longer qualified: show junk so a late sample shows
        opa <= ~a;
        opb <= ~b;
    endtask : issue
endmodule : sgd_issuer
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the SIMD general data datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [127:0] A = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
    localparam logic [127:0] B = 128'hfedc_ba98_7654_3210_0123_4567_89ab_cdef;
    logic             clk, resetn, reg_wr, reg_rd, op_valid, op_quad;
    logic             op_unsigned, res_valid, res_illegal, sat_flag;
    logic [127:0]     opa, opb, res_data;
    logic [31:0]      reg_wdata, reg_rdata;
    logic [3:0]       reg_addr;
    logic [1:0]       op_esize;
    logic [7:0]       op_imm;
    logic [2:0]       op_imm_shape;
    sgd_pkg::sgd_op_t op_code;
    logic [31:0]      core_scalar = 32'h1234_5678;
    logic [5:0]       op_fbits = 6'h00;
    logic [3:0]       op_lane = 4'h0;
    logic             op_imm_float = 1'b0;
    int               failures = 0, num_checks = 0, cycles = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    sgd_issuer i_sgd_issuer (.*);
    sgd_datapath i_sgd_datapath (.*);
    task automatic chk(input string n, input logic [127:0] e,
                       input logic [127:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Reads check d in the cycle after the strobe
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 if (!w) chk("reg_rdata", {96'h0, d}, {96'h0, reg_rdata});
    endtask : acc
    // f: flag, illegal, unsigned type from bit 0 up
    task automatic run(input sgd_pkg::sgd_op_t c, input logic q,
                       input logic [1:0] e, input logic [7:0] i,
                       input logic [2:0] s, input logic [127:0] a,
                       input logic [127:0] x, input logic [2:0] f);
        i_sgd_issuer.issue(c, q, e, f[2], i, s, a, B);
        #1 chk("res_valid", 128'h1, {127'h0, res_valid});
        chk("res_illegal", {127'h0, f[1]}, {127'h0, res_illegal});
        chk("res_data", x, res_data);
        chk("sat_flag", {127'h0, f[0]}, {127'h0, sat_flag});
    endtask : run
    task automatic final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        acc(1'b0, 4'h0, 32'h0000_0000);
        acc(1'b0, 4'h4, 32'h0000_0001);
        acc(1'b0, 4'h8, 32'h0000_0000);
        run(sgd_pkg::OP_REV_HALF, 1, 2'h0, 8'h00, 3'h0, A,
            128'h1100_3322_5544_7766_9988_bbaa_ddcc_ffee, 0);
        run(sgd_pkg::OP_REV_WORD, 0, 2'h0, 8'h00, 3'h0, A,
            128'hbbaa_9988_ffee_ddcc, 0);
        run(sgd_pkg::OP_REV_DWORD, 1, 2'h2, 8'h00, 3'h0, A,
            128'h4455_6677_0011_2233_ccdd_eeff_8899_aabb, 0);
        run(sgd_pkg::OP_BYTE_EXTRACT, 1, 2'h0, 8'h0f, 3'h0, A,
            128'hdcba_9876_5432_1001_2345_6789_abcd_ef00, 0);
        run(sgd_pkg::OP_BYTE_EXTRACT, 0, 2'h0, 8'h08, 3'h0, A,
            128'h0, 3'h2);
        run(sgd_pkg::OP_IMM_FILL, 1, 2'h2, 8'hab, 3'h2, A,
            128'h00ab_0000_00ab_0000_00ab_0000_00ab_0000, 0);
        run(sgd_pkg::OP_INV_IMM_FILL, 0, 2'h1, 8'h12, 3'h1, A,
            128'hedff_edff_edff_edff, 0);
        run(sgd_pkg::OP_CORE_DUP, 0, 2'h1, 8'h00, 3'h0, A,
            128'h5678_5678_5678_5678, 0);
        run(sgd_pkg::OP_WIDEN, 1, 2'h0, 8'h00, 3'h0, A,
            128'hff88_ff99_ffaa_ffbb_ffcc_ffdd_ffee_ffff, 0);
        run(sgd_pkg::OP_TRUNC_NARROW, 1, 2'h2, 8'h00, 3'h0, A,
            128'h2233_6677_aabb_eeff, 0);
        run(sgd_pkg::OP_CONV_S2F, 1, 2'h2, 8'h00, 3'h0,
            128'h0100_0001_0000_0001, 128'h4b80_0000_3f80_0000, 0);
        run(sgd_pkg::OP_CONV_F2S, 0, 2'h2, 8'h00, 3'h0,
            128'hc030_0000_4030_0000, 128'hffff_fffe_0000_0002, 0);
        run(sgd_pkg::OP_SAT_NARROW, 1, 2'h2, 8'h00, 3'h0,
            128'hffff_ffff_0000_1234_ffff_0000_0001_0000,
            128'hffff_1234_8000_7fff, 1);
        run(sgd_pkg::OP_REV_HALF, 0, 2'h0, 8'h00, 3'h0, A,
            128'h9988_bbaa_ddcc_ffee, 1);
        acc(1'b0, 4'h0, 32'h0800_0000);
        acc(1'b1, 4'h0, 32'h0000_0000);
        run(sgd_pkg::OP_SAT_NARROW, 0, 2'h1, 8'h00, 3'h0,
            128'h0100_007f_8000, 128'h7f_7f80, 1);
        run(sgd_pkg::OP_SAT_NARROW_SU, 1, 2'h1, 8'h00, 3'h0,
            128'h0001_0100_007f_00ff_0000_ffff_1234_8000,
            128'h01ff_7fff_0000_ff00, 1);
        run(sgd_pkg::OP_SAT_NARROW, 0, 2'h3, 8'h00, 3'h0,
            128'h1_0000_0000_0000_0000_dead_beef, 128'hffff_ffff_dead_beef, 5);
        run(sgd_pkg::OP_IMM_FILL, 0, 2'h3, 8'h5a, 3'h0, A,
            128'h00ff_00ff_ff00_ff00, 1);
        run(sgd_pkg::OP_CONV_H2F, 1, 2'h1, 8'h00, 3'h0,
            128'h7c00_0000_c000_3c00,
            128'h7f80_0000_0000_0000_c000_0000_3f80_0000, 1);
        run(sgd_pkg::OP_CONV_F2H, 0, 2'h2, 8'h00, 3'h0,
            128'h7f80_0000_0000_0000_c000_0000_3f80_0000,
            128'h7c00_0000_c000_3c00, 1);
        @(posedge clk);
        op_lane <= 4'h1;
        op_fbits <= 6'h04;
        op_imm_float <= 1'b1;
        run(sgd_pkg::OP_LANE_DUP, 0, 2'h2, 8'h00, 3'h0, A,
            128'h8899_aabb_8899_aabb, 1);
        run(sgd_pkg::OP_CONV_F2U, 0, 2'h2, 8'h00, 3'h0,
            128'hc030_0000_4030_0000, 128'h2c, 1);
        run(sgd_pkg::OP_CONV_U2F, 0, 2'h2, 8'h00, 3'h0,
            128'hffff_ffff_0000_0020, 128'h4d80_0000_4000_0000, 1);
        run(sgd_pkg::OP_IMM_FILL, 0, 2'h2, 8'hb1, 3'h0, A,
            128'hc308_0000_c308_0000, 1);
        final_report();
    end
endmodule : tb
`default_nettype wire
